// file: osf_params.svh
// constants for the frame-0 output switch and over-current logic
`ifndef OSF_PARAMS_SVH
`define OSF_PARAMS_SVH

// --------------------------------------------------------------
// frame layout
// --------------------------------------------------------------
`define OSF_W 24
`define OSF_BIT_NOERR 0
`define OSF_BIT_HB_FIRST 1
`define OSF_BIT_HSA 14
`define OSF_BIT_HSB 15
`define OSF_BIT_HSC 17
`define OSF_BIT_DUTY 21
`define OSF_BIT_ENABLE 23
`define OSF_BIT_REC_HSA 19
`define OSF_BIT_REC_HSB 20
`define OSF_BIT_REC_HSC 22
`define OSF_CTRL0_MASK 24'h22c07e
`define OSF_CTRL0_RESET 24'h000000
`define OSF_STATUS_RESET 24'h000001

// --------------------------------------------------------------
// recovery timing
// --------------------------------------------------------------
`define OSF_CLK_MHZ 100
`define OSF_REC_OFF_LONG_NS 4000
`define OSF_REC_OFF_SHORT_NS 1000
`define OSF_REC_LONG_CYC (`OSF_REC_OFF_LONG_NS * `OSF_CLK_MHZ / 1000)
`define OSF_REC_SHORT_CYC (`OSF_REC_OFF_SHORT_NS * `OSF_CLK_MHZ / 1000)

`endif

// file: osf_pkg.sv
// types shared by the frame-0 output switch logic
package osf_pkg;

  // --------------------------------------------------------------
  // second word pair, as seen by this block
  // --------------------------------------------------------------
  typedef struct packed {
    logic [23:0] ctrl1_word;
    logic [8:0] pwm_en;
    logic [8:0] pwm_sel_b;
  } osf_cfg_s;

  // --------------------------------------------------------------
  // switch drive levels
  // --------------------------------------------------------------
  typedef struct packed {
    logic [2:0] upper_switch;
    logic [2:0] lower_switch;
    logic high_side_a;
    logic high_side_b;
    logic high_side_c;
  } osf_drv_s;

  // output index (0..8) to its bit in the control and status words
  function automatic logic [4:0] osf_bit_of(input int unsigned idx);
    case (idx)
      6: osf_bit_of = 5'd14;
      7: osf_bit_of = 5'd15;
      8: osf_bit_of = 5'd17;
      default: osf_bit_of = 5'(idx + 1);
    endcase
  endfunction

endpackage

// file: osf_spi_shift.sv
// serial frame shifter sampled by the system clock
`include "osf_params.svh"
module osf_spi_shift (
  input wire logic clock,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic csn,
  input wire logic sdi,
  input wire logic [23:0] tx_word,
  output logic sdo,
  output logic sdo_oe,
  output logic [23:0] rx_word,
  output logic rx_valid
);
  import osf_pkg::*;

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [2:0] sclk_q;
  logic [2:0] csn_q;
  logic [1:0] sdi_q;
  logic [4:0] cnt_q;
  logic [23:0] sh_q;
  logic sdo_q;
  logic valid_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 3'h0;
      csn_q <= 3'h7;
      sdi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk};
      csn_q <= {csn_q[1:0], csn};
      sdi_q <= {sdi_q[0], sdi};
    end
  end

  // edges judged on second and third stages only
  wire sclk_rise = sclk_q[1] & ~sclk_q[2];
  wire sclk_fall = ~sclk_q[1] & sclk_q[2];
  wire csn_fall = ~csn_q[1] & csn_q[2];
  wire csn_rise = csn_q[1] & ~csn_q[2];
  wire sel = ~csn_q[2];

  // --------------------------------------------------------------
  // shift register, msb first
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sh_q <= 24'h000000;
      cnt_q <= 5'h00;
      sdo_q <= 1'b0;
    end else if (csn_fall) begin
      sh_q <= tx_word;
      sdo_q <= tx_word[23];
      cnt_q <= 5'h00;
    end else if (sel && sclk_rise) begin
      sh_q <= {sh_q[22:0], sdi_q[1]};
      // saturate so a long frame never looks complete
      cnt_q <= (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
    end else if (sel && sclk_fall) begin
      sdo_q <= sh_q[23];
    end
  end

  // only an exact 24-clock frame is accepted
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= csn_rise && (cnt_q == 5'(`OSF_W));
    end
  end

  assign sdo = sdo_q;
  assign sdo_oe = sel;
  assign rx_word = sh_q;
  assign rx_valid = valid_q;
endmodule // osf_spi_shift

// file: osf_frame0.sv
// frame-0 output switch control and over-current status logic
`include "osf_params.svh"
// Overview of operation
// - control bits 17, 15, 14 switch on high_side_c, high_side_b, high_side_a
// - bits 1 to 6 drive half bridge switches, low odd, high even
// - with pwm enabled, driver on only while its gate input is high
// - both switches of one half bridge never conduct together
// - over-current sets status bit at control position and disables driver
// - recovery enabled: driver returns after delay set by bit 21
// - status bit 0 is nor of status bits 1 to 22 of both words
// - global enable bit 23 selects active; clearing or reset gives standby
// - high-side recovery enables sit at word-1 bits 19, 20, 22
module osf_frame0 (
  input wire logic clock,
  input wire logic resetn,
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic gate_input_a,
  input wire logic gate_input_b,
  input wire logic [8:0] oc_detect,
  input osf_pkg::osf_cfg_s cfg,
  input wire logic [21:0] status1_flags,
  input wire logic clear_flags,
  output osf_pkg::osf_drv_s drivers,
  output logic [23:0] status0_word,
  output logic [23:0] ctrl0_word
);
  import osf_pkg::*;

  // --------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------
  logic [1:0] gate_a_q;
  logic [1:0] gate_b_q;
  logic [8:0] oc_s1_q;
  logic [8:0] oc_s2_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gate_a_q <= 2'h0;
      gate_b_q <= 2'h0;
      oc_s1_q <= 9'h000;
      oc_s2_q <= 9'h000;
    end else begin
      gate_a_q <= {gate_a_q[0], gate_input_a};
      gate_b_q <= {gate_b_q[0], gate_input_b};
      oc_s1_q <= oc_detect;
      oc_s2_q <= oc_s1_q;
    end
  end

  // --------------------------------------------------------------
  // serial frame
  // --------------------------------------------------------------
  logic [23:0] rx_word;
  logic rx_valid;
  logic [23:0] status_q;

  osf_spi_shift u_shift (
    .clock(clock),
    .resetn(resetn),
    .sclk(spi_sclk),
    .csn(spi_csn),
    .sdi(spi_sdi),
    .tx_word(status_q),
    .sdo(spi_sdo),
    .sdo_oe(spi_sdo_oe),
    .rx_word(rx_word),
    .rx_valid(rx_valid)
  );

  // --------------------------------------------------------------
  // control word
  // --------------------------------------------------------------
  logic active;
  logic [23:0] ctrl0_q;

  assign active = cfg.ctrl1_word[`OSF_BIT_ENABLE];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl0_q <= `OSF_CTRL0_RESET;
    end else if (!active) begin
      ctrl0_q <= `OSF_CTRL0_RESET;
    end else if (rx_valid) begin
      ctrl0_q <= rx_word & `OSF_CTRL0_MASK;
    end
  end

  // --------------------------------------------------------------
  // per-output request
  // --------------------------------------------------------------
  logic [8:0] req;
  logic [8:0] rec_en;

  always_comb begin
    for (int i = 0; i < 9; i++) begin
      req[i] = ctrl0_q[osf_bit_of(i)];
      if (cfg.pwm_en[i]) begin
        req[i] = req[i] & (cfg.pwm_sel_b[i] ? gate_b_q[1] : gate_a_q[1]);
      end
    end
  end

  assign rec_en = {cfg.ctrl1_word[`OSF_BIT_REC_HSC], cfg.ctrl1_word[`OSF_BIT_REC_HSB],
                   cfg.ctrl1_word[`OSF_BIT_REC_HSA], 6'h00};

  // --------------------------------------------------------------
  // over-current flags
  // --------------------------------------------------------------
  logic [8:0] oc_flag_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      oc_flag_q <= 9'h000;
    end else if (!active) begin
      oc_flag_q <= 9'h000;
    end else begin
      // latch flag; reset bit clears, new event wins
      oc_flag_q <= oc_s2_q | (oc_flag_q & ~{9{clear_flags}});
    end
  end

  // --------------------------------------------------------------
  // recovery timers, high sides only
  // --------------------------------------------------------------
  logic [8:0] rec_cnt_q [3];
  logic [8:0] rec_load;

  // short off time gives the higher duty cycle
  assign rec_load = ctrl0_q[`OSF_BIT_DUTY] ? 9'(`OSF_REC_SHORT_CYC) : 9'(`OSF_REC_LONG_CYC);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < 3; k++) begin
        rec_cnt_q[k] <= 9'h000;
      end
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (!active) begin
          rec_cnt_q[k] <= 9'h000;
        end else if (oc_s2_q[6 + k]) begin
          rec_cnt_q[k] <= rec_load;
        end else if (rec_cnt_q[k] != 9'h000) begin
          rec_cnt_q[k] <= rec_cnt_q[k] - 9'h001;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // drive with protection
  // --------------------------------------------------------------
  logic [8:0] allow;
  logic [8:0] drv_d;
  logic [8:0] drv_q;

  always_comb begin
    for (int i = 0; i < 9; i++) begin
      // disable on flag; held off until cleared unless recovery is enabled, then until the timer expires
      allow[i] = active & req[i] & ~oc_s2_q[i] & ~(oc_flag_q[i] & ~rec_en[i]);
    end
    for (int k = 0; k < 3; k++) begin
      allow[6 + k] = allow[6 + k] & (rec_cnt_q[k] == 9'h000);
    end
    drv_d = allow;
    for (int b = 0; b < 3; b++) begin
      // no cross conduction, one idle cycle between sides
      drv_d[2 * b] = allow[2 * b] & ~allow[2 * b + 1] & ~drv_q[2 * b + 1];
      drv_d[2 * b + 1] = allow[2 * b + 1] & ~allow[2 * b] & ~drv_q[2 * b];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      drv_q <= 9'h000;
    end else begin
      drv_q <= drv_d;
    end
  end

  assign drivers.lower_switch = {drv_q[4], drv_q[2], drv_q[0]};
  assign drivers.upper_switch = {drv_q[5], drv_q[3], drv_q[1]};
  assign drivers.high_side_a = drv_q[6];
  assign drivers.high_side_b = drv_q[7];
  assign drivers.high_side_c = drv_q[8];

  // --------------------------------------------------------------
  // status word
  // --------------------------------------------------------------
  logic [23:0] status_d;

  always_comb begin
    status_d = 24'h000000;
    for (int i = 0; i < 9; i++) begin
      status_d[osf_bit_of(i)] = oc_flag_q[i];
    end
    status_d[`OSF_BIT_NOERR] = ~(|status_d[22:1] | |status1_flags);
  end

  // registered so the frame sees a stable word
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_q <= `OSF_STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  assign status0_word = status_q;
  assign ctrl0_word = ctrl0_q;
endmodule // osf_frame0

// file: osf_chk.sv
// assertion checker for the frame-0 output switch block
`include "osf_params.svh"
module osf_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [8:0] oc_detect,
  input wire logic gate_input_a,
  input osf_pkg::osf_cfg_s cfg,
  input wire logic [21:0] status1_flags,
  input osf_pkg::osf_drv_s drivers,
  input wire logic [23:0] status0_word,
  input wire logic [23:0] ctrl0_word
);
  timeunit 1ns;
  timeprecision 1ns;
  import osf_pkg::*;
  // ----------------------------
  // properties
  // ----------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  chk_no_shoot: assert property (!(|(drivers.upper_switch & drivers.lower_switch)))
    else $error("both switches of a bridge on");
  chk_noerr_word: assert property (status0_word[0] |-> !(|status0_word[22:1]))
    else $error("no-error bit set beside a flag");
  chk_noerr_flags: assert property ((|status1_flags) [*3] |-> !status0_word[0])
    else $error("no-error bit ignores word 1");
  chk_unused_zero: assert property (status0_word[13:7] == 7'h00 && !status0_word[16])
    else $error("unused status bit set");
  chk_ctrl_mask: assert property ((ctrl0_word & ~`OSF_CTRL0_MASK) == 24'h000000)
    else $error("unused control bit kept");
  chk_hs_off: assert property ((!ctrl0_word[17]) [*3] |-> !drivers.high_side_c)
    else $error("high side c on without its bit");
  chk_hb_off: assert property ((!ctrl0_word[1]) [*3] |-> !drivers.lower_switch[0])
    else $error("bridge a low side on without its bit");
  chk_oc_off: assert property ((oc_detect[8] && cfg.ctrl1_word[23]) [*5] |->
    status0_word[17] && !drivers.high_side_c)
    else $error("over-current not flagged or driver on");
  chk_pwm_gate: assert property
    ((cfg.pwm_en[6] && !cfg.pwm_sel_b[6] && !gate_input_a) [*5] |-> !drivers.high_side_a)
    else $error("gated driver on while gate low");
  chk_standby: assert property
    ((!cfg.ctrl1_word[23]) [*4] |-> ctrl0_word == 24'h000000 && drivers == 9'h000)
    else $error("standby left bits set");
endmodule // osf_chk

bind osf_frame0 osf_chk chk_u (.clock(clock), .resetn(resetn), .oc_detect(oc_detect),
  .gate_input_a(gate_input_a), .cfg(cfg), .status1_flags(status1_flags), .drivers(drivers),
  .status0_word(status0_word), .ctrl0_word(ctrl0_word));

// file: osf_host.sv
// host-side serial master model for the frame-0 block
module osf_host (
  input wire logic clock,
  input wire logic spi_sdo,
  output logic spi_sclk,
  output logic spi_csn,
  output logic spi_sdi
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------
  // frame engine, 80 ns link clock
  // ----------------------------
  initial begin
    spi_sclk = 1'b0;
    spi_csn = 1'b1;
    spi_sdi = 1'b0;
  end
  task automatic xfer(input logic [23:0] w, output logic [23:0] r);
    @(posedge clock);
    spi_csn <= 1'b0;
    repeat (6) @(posedge clock);
    for (int i = 23; i >= 0; i--) begin
      spi_sdi <= w[i];
      repeat (4) @(posedge clock);
      spi_sclk <= 1'b1;
      repeat (4) @(posedge clock);
      // sampled just before the fall, where sdo is long settled
      r[i] = spi_sdo;
      spi_sclk <= 1'b0;
    end
    repeat (4) @(posedge clock);
    spi_csn <= 1'b1;
    // released line must not look like a held bit
    spi_sdi <= ~spi_sdi;
    repeat (6) @(posedge clock);
  endtask
endmodule // osf_host

// file: tb_top.sv
// self-checking bench for the frame-0 output switch block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import osf_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic sclk, csn, sdi, sdo, oe, ga, gb, clr;
  logic [8:0] oc;
  logic [21:0] st1;
  logic [23:0] st0, c0, r;
  osf_cfg_s cfg;
  osf_drv_s drv;
  int fail_count = 0;
  int tests_run = 0;
  always #5 clock = ~clock;
  osf_frame0 dut_u (.clock(clock), .resetn(resetn), .spi_sclk(sclk), .spi_csn(csn),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe), .gate_input_a(ga), .gate_input_b(gb),
    .oc_detect(oc), .cfg(cfg), .status1_flags(st1), .clear_flags(clr), .drivers(drv),
    .status0_word(st0), .ctrl0_word(c0));
  osf_host host_u (.clock(clock), .spi_sdo(sdo), .spi_sclk(sclk), .spi_csn(csn), .spi_sdi(sdi));
  // ----------------------------
  // shared tasks
  // ----------------------------
  task automatic final_report();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic ck(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [23:0] w);
    fork
      host_u.xfer(w, r);
      begin
        repeat (20) @(posedge clock);
        ck(oe === 1'b1, "sdo driven in frame");
      end
    join
    repeat (10) @(posedge clock);
    ck(oe === 1'b0, "sdo released");
  endtask
  function automatic osf_drv_s exp(input logic [23:0] c);
    logic [2:0] up, lo;
    up = {c[6], c[4], c[2]};
    lo = {c[5], c[3], c[1]};
    exp = '{up & ~lo, lo & ~up, c[14], c[15], c[17]};
  endfunction
  task automatic pulse_clear();
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
  // ----------------------------
  // scenarios
  // ----------------------------
  task automatic t_map();
    logic [23:0] w [12] = '{24'h000002, 24'h000004, 24'h000008, 24'h000010, 24'h000020,
      24'h000040, 24'h004000, 24'h008000, 24'h020000, 24'h000006, 24'h000018, 24'hffffff};
    foreach (w[i]) begin
      wr(w[i]);
      ck(c0 === (w[i] & 24'h22c07e), "control word");
      ck(drv === exp(w[i]), "driver map");
    end
    $display("t_map done");
  endtask
  task automatic t_pwm();
    wr(24'h004000);
    cfg.pwm_en <= 9'h040;
    repeat (8) @(posedge clock);
    ck(drv.high_side_a === 1'b0, "gate a low");
    ga <= 1'b1;
    repeat (8) @(posedge clock);
    ck(drv.high_side_a === 1'b1, "gate a high");
    cfg.pwm_sel_b <= 9'h040;
    repeat (8) @(posedge clock);
    ck(drv.high_side_a === 1'b0, "gate b low");
    cfg.pwm_en <= 9'h000;
    $display("t_pwm done");
  endtask
  task automatic t_oc();
    wr(24'h000002);
    oc[0] <= 1'b1;
    repeat (6) @(posedge clock);
    ck(st0[1:0] === 2'b10 && drv.lower_switch[0] === 1'b0, "flag set");
    oc[0] <= 1'b0;
    wr(24'h000002);
    ck(r[1:0] === 2'b10 && drv.lower_switch[0] === 1'b0, "held off");
    pulse_clear();
    ck(st0 === 24'h000001 && drv.lower_switch[0] === 1'b1, "cleared");
    $display("t_oc done");
  endtask
  task automatic t_rec();
    int k, n;
    cfg.ctrl1_word <= 24'h880000;
    for (int d = 0; d < 2; d++) begin
      n = d ? 100 : 400;
      wr(24'h004000 | (24'(d) << 21));
      oc[6] <= 1'b1;
      repeat (6) @(posedge clock);
      ck(st0[14] === 1'b1 && drv.high_side_a === 1'b0, "oc off");
      oc[6] <= 1'b0;
      for (k = 0; k < 500 && drv.high_side_a !== 1'b1; k++) @(posedge clock);
      if (k == 500) begin
        fail_count++;
        final_report();
      end
      ck(k >= n && k <= n + 10 && st0[14] === 1'b1, "recovery delay");
      pulse_clear();
    end
    cfg.ctrl1_word <= 24'h800000;
    $display("t_rec done");
  endtask
  task automatic t_misc();
    st1 <= 22'h000001;
    repeat (4) @(posedge clock);
    ck(st0[0] === 1'b0, "word 1 flag");
    st1 <= 22'h000000;
    wr(24'h020000);
    oc[8] <= 1'b1;
    repeat (6) @(posedge clock);
    ck(st0[17] === 1'b1 && st0[0] === 1'b0 && drv.high_side_c === 1'b0, "hsc latched");
    oc[8] <= 1'b0;
    cfg.ctrl1_word <= 24'h000000;
    repeat (4) @(posedge clock);
    ck(c0 === 24'h000000 && drv === 9'h000 && st0 === 24'h000001, "standby");
    wr(24'h020000);
    ck(c0 === 24'h000000, "write in standby");
    $display("t_misc done");
  endtask
  initial begin
    {ga, gb, clr, oc, st1} = '0;
    cfg = '0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    ck(st0 === 24'h000001 && c0 === 24'h000000, "reset values");
    cfg.ctrl1_word <= 24'h800000;
    t_map();
    t_pwm();
    t_oc();
    t_rec();
    t_misc();
    final_report();
  end
endmodule // tb_top
